// [hspd_pkg.sv]
// Shared constants and types for the high-side switch PWM and diagnosis block
`default_nettype none
package hspd_pkg;

  // Clock and timing
  localparam int CLK_HZ          = 125_000_000;
  localparam int CLK_MHZ         = 125;
  localparam int OL_FILTER_US    = 64;
  localparam int OL_FILTER_CYC   = OL_FILTER_US * CLK_MHZ;
  localparam int OC_FILTER_US    = 16;
  localparam int OC_FILTER_CYC   = OC_FILTER_US * CLK_MHZ;
  localparam int PWM_FREQ_LO_HZ  = 200;
  localparam int PWM_FREQ_HI_HZ  = 400;
  localparam int PWM_STEPS       = 256;
  localparam int PWM_STEP_CYC_LO = CLK_HZ / (PWM_FREQ_LO_HZ * PWM_STEPS);
  localparam int PWM_STEP_CYC_HI = CLK_HZ / (PWM_FREQ_HI_HZ * PWM_STEPS);
  localparam int PRE_W           = 12;
  localparam int FILT_W          = 16;

  // Geometry
  localparam int NUM_OUT  = 4;
  localparam int NUM_PWM  = 2;
  localparam int DUTY_W   = 8;
  localparam int SRC_W    = 3;
  localparam int ADDR_W   = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OUTPUT_SOURCE_CTRL_A_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] OUTPUT_SOURCE_CTRL_B_OFS    = 8'h04;
  localparam logic [ADDR_W-1:0] PULSE_GEN1_DUTY_REG_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] PULSE_GEN2_DUTY_REG_OFS     = 8'h0C;
  localparam logic [ADDR_W-1:0] PULSE_PERIOD_SELECT_REG_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] OPEN_LOAD_STATUS_REG_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS              = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS                = 8'h1C;
  localparam logic [ADDR_W-1:0] BLOCK_STATUS_OFS            = 8'h20;

  // Field positions
  localparam int SRC_LO_POS  = 0;
  localparam int SRC_HI_POS  = 4;
  localparam int STAT_MODE_POS = 4;
  localparam int STAT_OC_POS   = 8;
  localparam int IRQ_OC_POS    = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Output drive source codes
  typedef enum logic [SRC_W-1:0] {
    SRC_OFF    = 3'h0,
    SRC_ON     = 3'h1,
    SRC_TIMER1 = 3'h2,
    SRC_TIMER2 = 3'h3,
    SRC_PWM1   = 3'h4,
    SRC_PWM2   = 3'h5
  } hspd_src_e;

  // Chip operating modes as seen by this block
  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'h0,
    MODE_STOP      = 3'h1,
    MODE_SLEEP     = 3'h2,
    MODE_RESTART   = 3'h3,
    MODE_FAIL_SAFE = 3'h4,
    MODE_INIT      = 3'h5
  } hspd_mode_e;

endpackage : hspd_pkg
`default_nettype wire

// [hspd_filter.sv]
// Persistence filter: qualifies a condition held for a number of clock cycles
`timescale 1ns/100ps
`default_nettype none
module hspd_filter
  import hspd_pkg::*;
#(
  parameter int CYCLES = 16
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic cond,
  output var  logic hit
);

  localparam logic [FILT_W-1:0] LAST = FILT_W'(CYCLES - 1);

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic              hit;
  } hspd_filter_s;

  hspd_filter_s q;
  hspd_filter_s next_q;

  always_comb begin
    next_q = q;
    if (!cond) begin
      // Any glitch of the condition restarts the full filter time
      next_q.cnt = '0;
      next_q.hit = 1'b0;
    end else if (q.cnt == LAST) begin
      next_q.hit = 1'b1;
    end else begin
      next_q.cnt = q.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hit = q.hit;

endmodule : hspd_filter
`default_nettype wire

// [hspd_pwm.sv]
// One 8-bit PWM generator with selectable 200 Hz or 400 Hz period
`timescale 1ns/100ps
`default_nettype none
module hspd_pwm
  import hspd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [DUTY_W-1:0] duty,
  input  wire logic              fast,
  output var  logic              pwm_out
);

  localparam logic [PRE_W-1:0] STEP_LAST_LO = PRE_W'(PWM_STEP_CYC_LO - 1);
  localparam logic [PRE_W-1:0] STEP_LAST_HI = PRE_W'(PWM_STEP_CYC_HI - 1);

  typedef struct packed {
    logic [PRE_W-1:0]  pre;
    logic [DUTY_W-1:0] step;
    logic              out;
  } hspd_pwm_s;

  hspd_pwm_s q;
  hspd_pwm_s next_q;

  always_comb begin
    next_q = q;
    // Step enable from the divider; 256 steps form one period
    if (q.pre >= (fast ? STEP_LAST_HI : STEP_LAST_LO)) begin
      next_q.pre  = '0;
      next_q.step = q.step + DUTY_W'(1);
    end else begin
      next_q.pre = q.pre + PRE_W'(1);
    end
    // On for duty/256 of the period; a duty change applies from the next clock cycle
    next_q.out = (next_q.step < duty);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pwm_out = q.out;

endmodule : hspd_pwm
`default_nettype wire

// [hspd_top.sv]
// High-side switch control: source select, PWM, open-load and overcurrent diagnosis, AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Open-load is only evaluated while the output is actually driven on.
// - Filtered low current on a driven output sets that output's own open-load flag.
// - An open load never switches the output off.
// - Open-load flags stay set until software writes one; set wins over clear.
// - Open-load must persist 64 us before it is reported.
// - Overcurrent must persist 16 us before the output is shut down.
// - Diagnosis and shutdown stay active in stop and sleep modes.
// - Configure outputs in normal mode; they keep running in stop and sleep.
// - Restart and fail-safe force all outputs off; the source fields are kept, so outputs resume afterwards.
// - Two PWM generators, each with its own 8-bit duty register.
// - Each generator picks 200 Hz or 400 Hz by its own select bit.
// - PWM appears on an output as soon as its source field selects it.
// - Each output selects timer 1, timer 2, PWM 1 or PWM 2 as source.
// - Field 000 is off, 001 on; overcurrent shutdown resets the field to off.
// - Source, duty and period writes are ignored during stop and sleep; flag clears and IRQ mask writes still apply.
module hspd_top
  import hspd_pkg::*;
#(
  parameter int OL_CYCLES = OL_FILTER_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Chip context
  input  wire logic [2:0]           sbc_mode,
  input  wire logic                 timer1_in,
  input  wire logic                 timer2_in,
  input  wire logic [NUM_OUT-1:0]   open_load_raw,
  input  wire logic [NUM_OUT-1:0]   over_current_raw,
  // Outputs
  output var  logic [NUM_OUT-1:0]   high_side_output,
  output var  logic                 irq
);

  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_full;
    logic                          w_full;
    logic [ADDR_W-1:0]             aw_addr;
    logic [DUTY_W-1:0]             w_byte;
    logic                          w_lane0;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    logic [NUM_OUT-1:0][SRC_W-1:0] src;
    logic [NUM_PWM-1:0][DUTY_W-1:0] duty;
    logic [NUM_PWM-1:0]            fast;
    logic [NUM_OUT-1:0]            ol_flag;
    logic [2*NUM_OUT-1:0]          irq_stat;
    logic [2*NUM_OUT-1:0]          irq_mask;
    logic [NUM_OUT-1:0]            ol_s1;
    logic [NUM_OUT-1:0]            ol_s2;
    logic [NUM_OUT-1:0]            ol_s3;
    logic [NUM_OUT-1:0]            ol_st;
    logic [NUM_OUT-1:0]            oc_s1;
    logic [NUM_OUT-1:0]            oc_s2;
    logic [NUM_OUT-1:0]            oc_s3;
    logic [NUM_OUT-1:0]            oc_st;
    logic [NUM_OUT-1:0]            hs_out;
    logic                          irq;
  } hspd_top_s;

  // Address and data channels are ready from reset, so a first request needs no wait
  localparam hspd_top_s RST_VAL = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
  localparam int        MODE_W  = $bits(hspd_mode_e);

  hspd_top_s q;
  hspd_top_s next_q;

  logic [NUM_PWM-1:0] pwm_wave;
  logic [NUM_OUT-1:0] ol_hit;
  logic [NUM_OUT-1:0] oc_hit;
  hspd_mode_e         mode;

  assign mode = hspd_mode_e'(sbc_mode);

  // Drive level of one output for its selected source
  function automatic logic src_drive(input logic [SRC_W-1:0] sel,
                                     input logic t1,
                                     input logic t2,
                                     input logic [NUM_PWM-1:0] pw);
    logic d;
    d = 1'b0;
    case (sel)
      SRC_ON:     d = 1'b1;
      SRC_TIMER1: d = t1;
      SRC_TIMER2: d = t2;
      SRC_PWM1:   d = pw[0];
      SRC_PWM2:   d = pw[1];
      default:    d = 1'b0;
    endcase
    return d;
  endfunction : src_drive

  // Registers are whole words; the two low address bits never select one
  function automatic logic [ADDR_W-1:0] word_ofs(input logic [ADDR_W-1:0] addr);
    return {addr[ADDR_W-1:2], 2'b00};
  endfunction : word_ofs

  // Stable level of a synchroniser: follow stage two once stage three agrees
  function automatic logic [NUM_OUT-1:0] sync_level(input logic [NUM_OUT-1:0] s2,
                                                    input logic [NUM_OUT-1:0] s3,
                                                    input logic [NUM_OUT-1:0] st);
    return (s2 & s3) | (st & (s2 ^ s3));
  endfunction : sync_level

  // Read decode; bit 32 flags an unmapped address
  function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] addr,
                                           input hspd_top_s s,
                                           input logic [2:0] md);
    logic [32:0] r;
    r = '0;
    case (word_ofs(addr))
      OUTPUT_SOURCE_CTRL_A_OFS: begin
        r[SRC_LO_POS +: SRC_W] = s.src[0];
        r[SRC_HI_POS +: SRC_W] = s.src[1];
      end
      OUTPUT_SOURCE_CTRL_B_OFS: begin
        r[SRC_LO_POS +: SRC_W] = s.src[2];
        r[SRC_HI_POS +: SRC_W] = s.src[3];
      end
      PULSE_GEN1_DUTY_REG_OFS:     r[DUTY_W-1:0] = s.duty[0];
      PULSE_GEN2_DUTY_REG_OFS:     r[DUTY_W-1:0] = s.duty[1];
      PULSE_PERIOD_SELECT_REG_OFS: r[NUM_PWM-1:0] = s.fast;
      OPEN_LOAD_STATUS_REG_OFS:    r[NUM_OUT-1:0] = s.ol_flag;
      IRQ_STATUS_OFS:              r[2*NUM_OUT-1:0] = s.irq_stat;
      IRQ_MASK_OFS:                r[2*NUM_OUT-1:0] = s.irq_mask;
      BLOCK_STATUS_OFS: begin
        r[NUM_OUT-1:0]            = s.hs_out;
        r[STAT_MODE_POS +: MODE_W] = md;
        r[STAT_OC_POS +: NUM_OUT] = s.oc_st;
      end
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction : reg_read

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PWM; gi++) begin : g_pwm
      hspd_pwm u_pwm (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .duty    (q.duty[gi]),
        .fast    (q.fast[gi]),
        .pwm_out (pwm_wave[gi])
      );
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_diag
      // Only a driven output is judged, so PWM off-phases never count as open load
      hspd_filter #(.CYCLES(OL_CYCLES)) u_ol_filt (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cond    (q.hs_out[gi] & q.ol_st[gi]),
        .hit     (ol_hit[gi])
      );
      hspd_filter #(.CYCLES(OC_FILTER_CYC)) u_oc_filt (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cond    (q.hs_out[gi] & q.oc_st[gi]),
        .hit     (oc_hit[gi])
      );
    end
  endgenerate

  always_comb begin
    logic        low_power;
    logic        forced_off;
    logic [32:0] rd;
    low_power  = 1'b0;
    forced_off = 1'b0;
    rd         = '0;
    next_q     = q;

    // Stop and sleep block source, duty and period writes; writes still get OKAY so software never stalls
    low_power  = (mode == MODE_STOP) || (mode == MODE_SLEEP);
    // Gating keeps the source fields, so outputs resume on return to normal mode
    forced_off = (mode == MODE_RESTART) || (mode == MODE_FAIL_SAFE);

    // Comparator inputs: three stages, accept a level once stages two and three agree
    next_q.ol_s1 = open_load_raw;
    next_q.ol_s2 = q.ol_s1;
    next_q.ol_s3 = q.ol_s2;
    next_q.ol_st = sync_level(q.ol_s2, q.ol_s3, q.ol_st);
    next_q.oc_s1 = over_current_raw;
    next_q.oc_s2 = q.oc_s1;
    next_q.oc_s3 = q.oc_s2;
    next_q.oc_st = sync_level(q.oc_s2, q.oc_s3, q.oc_st);

    // Write address and data are taken independently, one write in flight
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_full = 1'b1;
      next_q.awready = 1'b0;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_full  = 1'b1;
      next_q.wready  = 1'b0;
      next_q.w_byte  = s_axi_wdata[DUTY_W-1:0];
      next_q.w_lane0 = s_axi_wstrb[0];
    end

    if (q.aw_full && q.w_full && !q.bvalid) begin
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = RESP_OKAY;
      case (word_ofs(q.aw_addr))
        OUTPUT_SOURCE_CTRL_A_OFS: begin
          if (q.w_lane0 && !low_power) begin
            next_q.src[0] = q.w_byte[SRC_LO_POS +: SRC_W];
            next_q.src[1] = q.w_byte[SRC_HI_POS +: SRC_W];
          end
        end
        OUTPUT_SOURCE_CTRL_B_OFS: begin
          if (q.w_lane0 && !low_power) begin
            next_q.src[2] = q.w_byte[SRC_LO_POS +: SRC_W];
            next_q.src[3] = q.w_byte[SRC_HI_POS +: SRC_W];
          end
        end
        PULSE_GEN1_DUTY_REG_OFS: begin
          if (q.w_lane0 && !low_power) begin
            next_q.duty[0] = q.w_byte;
          end
        end
        PULSE_GEN2_DUTY_REG_OFS: begin
          if (q.w_lane0 && !low_power) begin
            next_q.duty[1] = q.w_byte;
          end
        end
        PULSE_PERIOD_SELECT_REG_OFS: begin
          if (q.w_lane0 && !low_power) begin
            next_q.fast = q.w_byte[NUM_PWM-1:0];
          end
        end
        OPEN_LOAD_STATUS_REG_OFS: begin
          if (q.w_lane0) begin
            next_q.ol_flag = q.ol_flag & ~q.w_byte[NUM_OUT-1:0];
          end
        end
        IRQ_STATUS_OFS: begin
          if (q.w_lane0) begin
            next_q.irq_stat = q.irq_stat & ~q.w_byte[2*NUM_OUT-1:0];
          end
        end
        IRQ_MASK_OFS: begin
          if (q.w_lane0) begin
            next_q.irq_mask = q.w_byte[2*NUM_OUT-1:0];
          end
        end
        // Status is read-only: a write is answered and changes nothing
        BLOCK_STATUS_OFS: next_q.bresp = RESP_OKAY;
        default:          next_q.bresp = RESP_SLVERR;
      endcase
    end

    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid  = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready  = 1'b1;
    end

    // Read channel, one read in flight
    // Read data is captured into a register when the address is taken, so it stands unchanged until taken
    if (s_axi_arvalid && q.arready) begin
      rd             = reg_read(s_axi_araddr, q, sbc_mode);
      next_q.arready = 1'b0;
      next_q.rvalid  = 1'b1;
      next_q.rdata   = rd[31:0];
      next_q.rresp   = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end

    // Hardware events come after the software clear so that a set in the same cycle wins
    next_q.ol_flag  = next_q.ol_flag | ol_hit;
    next_q.irq_stat = next_q.irq_stat | {oc_hit, ol_hit};
    // Shutdown clears the field itself, so the output stays off until software rewrites it
    for (int i = 0; i < NUM_OUT; i++) begin
      if (oc_hit[i]) begin
        next_q.src[i] = SRC_OFF;
      end
    end

    // Open load leaves the drive alone; only mode gating and overcurrent switch off
    for (int i = 0; i < NUM_OUT; i++) begin
      next_q.hs_out[i] = !forced_off && src_drive(next_q.src[i], timer1_in, timer2_in, pwm_wave);
    end

    // Level interrupt while any unmasked sticky event is set
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= RST_VAL;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_arready    = q.arready;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign s_axi_rvalid     = q.rvalid;
  assign high_side_output = q.hs_out;
  assign irq              = q.irq;

endmodule : hspd_top
`default_nettype wire

// [hspd_checker.sv]
// Concurrent checks on the high-side switch control block ports
`timescale 1ns/100ps
`default_nettype none
module hspd_checker
  import hspd_pkg::*;
#(
  parameter int OL_CYCLES = OL_FILTER_CYC
) (
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [2:0]         sbc_mode,
  input wire logic [NUM_OUT-1:0] over_current_raw,
  input wire logic [NUM_OUT-1:0] high_side_output
);
  // Filter plus synchroniser and output register slack
  localparam int OC_LIM = 2010;
  logic [11:0] oc_cnt;
  logic        off_mode;
  assign off_mode = (sbc_mode == MODE_RESTART) || (sbc_mode == MODE_FAIL_SAFE);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) oc_cnt <= 12'h000;
    else if (over_current_raw[0] && high_side_output[0]) oc_cnt <= oc_cnt + 12'h001;
    else oc_cnt <= 12'h000;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_gate_off_modes: assert property (
    off_mode [*2] |-> high_side_output == 4'h0) else $error("output on in restart or fail-safe");
  a_oc_cut_bound: assert property (
    oc_cnt <= OC_LIM) else $error("overcurrent output not shut down in time");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_aw_busy: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("second address taken");
  a_ar_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while answering");
  c_gate_off: cover property (off_mode ##1 off_mode);
  c_oc_cut: cover property (oc_cnt == 12'h7D0);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : hspd_checker
bind hspd_top hspd_checker #(.OL_CYCLES(OL_CYCLES)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sbc_mode(sbc_mode), .over_current_raw(over_current_raw), .high_side_output(high_side_output));
`default_nettype wire

// [hspd_load_model.sv]
// Load model: current comparators driven by switch state and per-output faults
`timescale 1ns/100ps
`default_nettype none
module hspd_load_model
  import hspd_pkg::*;
#(
  parameter int SLOW = 0
) (
  input  wire logic               ref_clk,
  input  wire logic [NUM_OUT-1:0] high_side_output,
  input  wire logic [NUM_OUT-1:0] open_cfg,
  input  wire logic [NUM_OUT-1:0] short_cfg,
  output var  logic [NUM_OUT-1:0] open_load_raw,
  output var  logic [NUM_OUT-1:0] over_current_raw
);
  logic [NUM_OUT-1:0] on_d;
  logic [NUM_OUT-1:0] on_seen;
  // Slow loads lag the switch edge by one cycle
  always_ff @(posedge ref_clk) on_d <= high_side_output;
  assign on_seen = (SLOW != 0) ? on_d : high_side_output;
  // An off switch carries no current, so its comparator reads low current
  assign open_load_raw = ~on_seen | open_cfg;
  assign over_current_raw = on_seen & short_cfg;
endmodule : hspd_load_model
`default_nettype wire

// [hspd_top_tb.sv]
// Self-checking bench for the high-side switch control block
`timescale 1ns/100ps
`default_nettype none
module hspd_top_tb
  import hspd_pkg::*;
;
  localparam int OL = 20;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [2:0]  sbc_mode = MODE_NORMAL;
  logic        timer1_in = 1'b0, timer2_in = 1'b0;
  logic [3:0]  open_cfg = 4'h0, short_cfg = 4'h0;
  logic [3:0]  olr, ocr, hs;
  logic [5:0]  tbl [2] = '{6'h36, 6'h3A};
  int          errors = 0, checks_done = 0, cyc = 0;

  hspd_top #(.OL_CYCLES(OL)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sbc_mode(sbc_mode), .timer1_in(timer1_in), .timer2_in(timer2_in),
    .open_load_raw(olr), .over_current_raw(ocr), .high_side_output(hs), .irq(irq));
  hspd_load_model #(.SLOW(1)) u_load (.ref_clk(ref_clk), .high_side_output(hs), .open_cfg(open_cfg),
    .short_cfg(short_cfg), .open_load_raw(olr), .over_current_raw(ocr));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("Error at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_pins(input logic [4:0] exp);
    checks_done++;
    if ({irq, hs} !== exp) begin
      errors++;
      $display("Error at %0t: irq and outputs %h expected %h", $time, {irq, hs}, exp);
    end
  endtask : cmp_pins

  // Address and data are released separately as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    bit aw_p;
    bit w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    // Late ready makes the slave hold its response for a cycle
    bready <= 1'b1;
    @(posedge ref_clk);
    bready <= 1'b0;
    cmp({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge ref_clk);
    rready <= 1'b0;
    cmp(rdata, e);
    cmp({30'h0, rresp}, {30'h0, er});
  endtask : rchk

  initial begin
    tick(12);
    sys_rst <= 1'b0;
    tick(1);
    rchk(IRQ_MASK_OFS, 32'h0000_0000, RESP_OKAY);
    rchk(8'h24, 32'h0000_0000, RESP_SLVERR);
    wr(8'h24, 8'h01, RESP_SLVERR);
    wr(PULSE_GEN1_DUTY_REG_OFS, 8'hFF, RESP_OKAY);
    wr(PULSE_GEN2_DUTY_REG_OFS, 8'h02, RESP_OKAY);
    wr(PULSE_PERIOD_SELECT_REG_OFS, 8'h01, RESP_OKAY);
    rchk(PULSE_GEN1_DUTY_REG_OFS, 32'h0000_00FF, RESP_OKAY);
    rchk(PULSE_PERIOD_SELECT_REG_OFS, 32'h0000_0001, RESP_OKAY);
    // Duty 255 stays high until the last step, far beyond this run
    for (int p = 0; p < 2; p++) begin
      timer1_in <= (p == 0);
      timer2_in <= (p == 1);
      for (int c = 0; c < 6; c++) begin
        wr(OUTPUT_SOURCE_CTRL_A_OFS, 8'(c), RESP_OKAY);
        tick(2);
        cmp_pins({4'h0, tbl[p][c]});
      end
    end
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0000, RESP_OKAY);
    wr(OUTPUT_SOURCE_CTRL_A_OFS, 8'h10, RESP_OKAY);
    wr(IRQ_MASK_OFS, 8'h12, RESP_OKAY);
    tick(10);
    open_cfg <= 4'h2;
    tick(OL - 10);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0000, RESP_OKAY);
    tick(30);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0002, RESP_OKAY);
    cmp_pins(5'h12);
    wr(OPEN_LOAD_STATUS_REG_OFS, 8'h02, RESP_OKAY);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0002, RESP_OKAY);
    open_cfg <= 4'h0;
    tick(30);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0002, RESP_OKAY);
    wr(OPEN_LOAD_STATUS_REG_OFS, 8'h0F, RESP_OKAY);
    wr(IRQ_STATUS_OFS, 8'hFF, RESP_OKAY);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0000, RESP_OKAY);
    cmp_pins(5'h02);
    wr(OUTPUT_SOURCE_CTRL_A_OFS, 8'h11, RESP_OKAY);
    short_cfg <= 4'h1;
    tick(1900);
    cmp_pins(5'h03);
    tick(150);
    cmp_pins(5'h12);
    rchk(OUTPUT_SOURCE_CTRL_A_OFS, 32'h0000_0010, RESP_OKAY);
    rchk(IRQ_STATUS_OFS, 32'h0000_0010, RESP_OKAY);
    short_cfg <= 4'h0;
    wr(IRQ_STATUS_OFS, 8'hFF, RESP_OKAY);
    wr(OUTPUT_SOURCE_CTRL_A_OFS, 8'h11, RESP_OKAY);
    tick(2);
    cmp_pins(5'h03);
    for (int m = 0; m < 2; m++) begin
      sbc_mode <= m ? MODE_SLEEP : MODE_STOP;
      tick(2);
      wr(OUTPUT_SOURCE_CTRL_A_OFS, 8'h00, RESP_OKAY);
      rchk(OUTPUT_SOURCE_CTRL_A_OFS, 32'h0000_0011, RESP_OKAY);
      cmp_pins(5'h03);
    end
    open_cfg <= 4'h1;
    tick(40);
    rchk(OPEN_LOAD_STATUS_REG_OFS, 32'h0000_0001, RESP_OKAY);
    cmp_pins(5'h03);
    open_cfg <= 4'h0;
    for (int m = 0; m < 2; m++) begin
      sbc_mode <= m ? MODE_FAIL_SAFE : MODE_RESTART;
      tick(3);
      cmp_pins(5'h00);
    end
    sbc_mode <= MODE_NORMAL;
    tick(3);
    cmp_pins(5'h03);
    wr(OUTPUT_SOURCE_CTRL_B_OFS, 8'h50, RESP_OKAY);
    tick(2);
    cmp_pins(5'h0B);
    rchk(OUTPUT_SOURCE_CTRL_B_OFS, 32'h0000_0050, RESP_OKAY);
    // Duty 2 at 200 Hz: on for the first two steps after reset, then off
    tick(12 + 2 * PWM_STEP_CYC_LO - 30 - cyc);
    cmp_pins(5'h0B);
    tick(60);
    cmp_pins(5'h03);
    final_report();
  end
endmodule : hspd_top_tb
`default_nettype wire
